/* File: hw/chc_regs.sv */
// Charger control-zero and charge current limit registers with the
// mode logic that they steer.
// Assumes a byte register port decoded by the serial management slave,
// and analog comparators/status presented as synchronous levels.
//
// How it works
// - Control-zero at 01h, all bits read/write, resets to 1Ah.
// - Bit 7 set disables pulse-frequency mode; only register reset clears it.
// - Writing bit 6 kicks the watchdog, then bit returns to zero.
// - Bit 5 enables boost; register reset or watchdog expiry clears it.
// - Both enables set: switch charge/boost automatically on adapter change.
// - Charging needs enable pin low, charge enable set, nonzero current code.
// - Bits 3:1 pick system floor 2.6 to 3.7 V; register reset only.
// - Bit 0 picks boost battery thresholds 2.8/3.0 V or 2.5/2.8 V.
// - Boost starts only above rising threshold with other conditions valid.
// - Charge current limit at 02h, all bits read/write, resets to 91h.
// - Bit 7 sets boost limit 0.5 A or 1.2 A; reset or watchdog.
// - Below 700 mA input limit, bit 6 picks partial or full transistor on.
// - Transistor fully on above 700 mA input limit or in boost.
// - Bits 5:0 fast charge code, 60 mA per step; reset or watchdog.
// - Fast charge defaults to code 010001, range up to code 110010.
// - Fast charge code zero disables charging.
// - Codes above 110010 act as 3000 mA.
// - Input limit field compared uses 100 mA offset, 100 mA steps.
`timescale 1ns/1ps

module chc_regs
  import chc_pkg::*;
#(
  parameter int INPUT_LIMIT_WIDTH = 5
) (
  input wire logic clock,
  input wire logic rst,
  input wire chc_req_type regReq,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic regResetCmd,
  input wire logic watchdogExpired,
  input wire logic chargeEnablePin_n,
  input wire logic adapterPresent,
  input wire logic boostOtherOk,
  input wire logic [12:0] batteryMv,
  input wire logic [INPUT_LIMIT_WIDTH-1:0] inputLimitCode,
  output chc_ctl_type ctl
);

  // ==========================================================
  // Register state
  logic [7:0] ctrlZero_r;
  logic [7:0] ctrlZero_nxt;
  logic [7:0] currLimit_r;
  logic [7:0] currLimit_nxt;
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;
  logic rdValid_r;
  logic rdValid_nxt;

  logic wrZero;
  logic wrCurr;

  assign wrZero = regReq.wrEn && (regReq.addr == CTRL_ZERO_ADDR);
  assign wrCurr = regReq.wrEn && (regReq.addr == CURR_LIMIT_ADDR);

  // Next register values: register reset, then watchdog, then host write
  always_comb begin
    ctrlZero_nxt = ctrlZero_r;
    currLimit_nxt = currLimit_r;
    // Kick bit self-clears one cycle after a write sets it
    ctrlZero_nxt[WATCHDOG_KICK_BIT] = 1'b0;
    if (regResetCmd) begin
      ctrlZero_nxt = CTRL_ZERO_RESET;
      currLimit_nxt = CURR_LIMIT_RESET;
    end else if (watchdogExpired) begin
      // Only watchdog-restored fields return to defaults
      ctrlZero_nxt = (ctrlZero_r & ~CTRL_ZERO_WDOG_MASK)
        | (CTRL_ZERO_RESET & CTRL_ZERO_WDOG_MASK);
      ctrlZero_nxt[WATCHDOG_KICK_BIT] = 1'b0;
      currLimit_nxt = (currLimit_r & ~CURR_LIMIT_WDOG_MASK)
        | (CURR_LIMIT_RESET & CURR_LIMIT_WDOG_MASK);
    end else begin
      if (wrZero) begin
        ctrlZero_nxt = regReq.wrData;
      end
      if (wrCurr) begin
        currLimit_nxt = regReq.wrData;
      end
    end
  end

  // Read port: registered byte, valid one cycle after the strobe
  always_comb begin
    rdValid_nxt = regReq.rdEn;
    rdData_nxt = rdData_r;
    if (regReq.rdEn) begin
      case (regReq.addr)
        CTRL_ZERO_ADDR: begin
          rdData_nxt = ctrlZero_r;
        end
        CURR_LIMIT_ADDR: begin
          rdData_nxt = currLimit_r;
        end
        default: begin
          rdData_nxt = UNMAPPED_READ;
        end
      endcase
    end
  end

  // Register the bank and read port
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrlZero_r <= CTRL_ZERO_RESET;
      currLimit_r <= CURR_LIMIT_RESET;
      rdData_r <= 8'h00;
      rdValid_r <= 1'b0;
    end else begin
      ctrlZero_r <= ctrlZero_nxt;
      currLimit_r <= currLimit_nxt;
      rdData_r <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
    end
  end

  assign regRdData = rdData_r;
  assign regRdValid = rdValid_r;

  // ==========================================================
  // Field decode
  logic boostEnable;
  logic chargeEnable;
  logic [2:0] sysFloorSel;
  logic boostExitSel;
  logic [5:0] fastCode;
  logic [5:0] fastCodeEff;
  logic [11:0] inputLimitMa;
  logic [12:0] exitMv;
  logic [12:0] startMv;
  logic [12:0] floorMv;
  logic chargeAllowed;
  logic boostStartOk;
  logic boostHoldOk;

  assign boostEnable = ctrlZero_r[BOOST_ENABLE_BIT];
  assign chargeEnable = ctrlZero_r[CHARGE_ENABLE_BIT];
  assign sysFloorSel = ctrlZero_r[SYS_FLOOR_LSB +: 3];
  assign boostExitSel = ctrlZero_r[BOOST_EXIT_SEL_BIT];
  assign fastCode = currLimit_r[FAST_CHARGE_LSB +: 6];

  // Clamp over-range fast charge codes to the top code
  assign fastCodeEff = (fastCode > FAST_CHARGE_MAX_CODE) ? FAST_CHARGE_MAX_CODE
    : fastCode;

  // Input limit in mA from its code with offset
  assign inputLimitMa = 12'(12'(inputLimitCode) * INPUT_LIMIT_STEP_MA)
    + INPUT_LIMIT_OFFSET_MA;

  // Boost battery thresholds from the select bit
  assign exitMv = boostExitSel ? BOOST_EXIT_MV_HI : BOOST_EXIT_MV_LO;
  assign startMv = boostExitSel ? BOOST_START_MV_HI : BOOST_START_MV_LO;

  // System floor voltage table
  always_comb begin
    case (sysFloorSel)
      3'h0: begin
        floorMv = SYS_FLOOR_MV_0;
      end
      3'h1: begin
        floorMv = SYS_FLOOR_MV_1;
      end
      3'h2: begin
        floorMv = SYS_FLOOR_MV_2;
      end
      3'h3: begin
        floorMv = SYS_FLOOR_MV_3;
      end
      3'h4: begin
        floorMv = SYS_FLOOR_MV_4;
      end
      3'h5: begin
        floorMv = SYS_FLOOR_MV_5;
      end
      3'h6: begin
        floorMv = SYS_FLOOR_MV_6;
      end
      default: begin
        floorMv = SYS_FLOOR_MV_7;
      end
    endcase
  end

  // Charging qualification
  assign chargeAllowed = !chargeEnablePin_n && chargeEnable
    && (fastCode != 6'h00);
  // Boost entry needs rising threshold, stay needs falling threshold
  assign boostStartOk = boostEnable && boostOtherOk && (batteryMv > startMv);
  assign boostHoldOk = boostEnable && boostOtherOk && (batteryMv >= exitMv);

  // ==========================================================
  // Operating mode
  chc_mode_type mode_r;
  chc_mode_type mode_nxt;

  // Automatic move between charge and boost as adapter comes and goes
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_IDLE: begin
        if (adapterPresent && chargeAllowed) begin
          mode_nxt = MODE_CHARGE;
        end else if (!adapterPresent && boostStartOk) begin
          mode_nxt = MODE_BOOST;
        end
      end
      MODE_CHARGE: begin
        if (!adapterPresent && boostStartOk) begin
          mode_nxt = MODE_BOOST;
        end else if (!adapterPresent || !chargeAllowed) begin
          mode_nxt = MODE_IDLE;
        end
      end
      MODE_BOOST: begin
        if (adapterPresent && chargeAllowed) begin
          mode_nxt = MODE_CHARGE;
        end else if (adapterPresent || !boostHoldOk) begin
          mode_nxt = MODE_IDLE;
        end
      end
      default: begin
        mode_nxt = MODE_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Output controls
  chc_ctl_type ctl_nxt;
  chc_ctl_type ctl_r;

  always_comb begin
    ctl_nxt.pulseFreqModeEn = !ctrlZero_r[PULSE_SKIP_DISABLE_BIT];
    ctl_nxt.watchdogKick = ctrlZero_r[WATCHDOG_KICK_BIT];
    ctl_nxt.chargeActive = (mode_nxt == MODE_CHARGE);
    ctl_nxt.boostActive = (mode_nxt == MODE_BOOST);
    // Full on when limit high or boosting, else follow the bit
    ctl_nxt.inputFetFullOn = (inputLimitMa > FET_FULL_ON_THRESH_MA)
      || (mode_nxt == MODE_BOOST)
      || currLimit_r[INPUT_FET_FULL_ON_BIT];
    ctl_nxt.sysFloorMv = floorMv;
    ctl_nxt.boostExitMv = exitMv;
    ctl_nxt.boostStartMv = startMv;
    ctl_nxt.boostLimitMa = currLimit_r[BOOST_CURRENT_LIMIT_BIT] ? BOOST_LIMIT_MA_HI
      : BOOST_LIMIT_MA_LO;
    ctl_nxt.chargeCurrentMa = 12'(12'(fastCodeEff) * FAST_CHARGE_STEP_MA);
  end

  // Register mode and controls
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_r <= MODE_IDLE;
      ctl_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      ctl_r <= ctl_nxt;
    end
  end

  assign ctl = ctl_r;

endmodule

/* File: pkg/chc_pkg.sv */
// Package for the charger control and current register pair.
// Assumes a byte-wide register port from the serial management slave.
package chc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] CTRL_ZERO_ADDR = 8'h01;
  localparam logic [7:0] CURR_LIMIT_ADDR = 8'h02;
  localparam logic [7:0] CTRL_ZERO_RESET = 8'h1a;
  localparam logic [7:0] CURR_LIMIT_RESET = 8'h91;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================
  // Field positions, control-zero register
  localparam int PULSE_SKIP_DISABLE_BIT = 7;
  localparam int WATCHDOG_KICK_BIT = 6;
  localparam int BOOST_ENABLE_BIT = 5;
  localparam int CHARGE_ENABLE_BIT = 4;
  localparam int SYS_FLOOR_LSB = 1;
  localparam int BOOST_EXIT_SEL_BIT = 0;

  // Field positions, charge current limit register
  localparam int BOOST_CURRENT_LIMIT_BIT = 7;
  localparam int INPUT_FET_FULL_ON_BIT = 6;
  localparam int FAST_CHARGE_LSB = 0;

  // Bits restored by a watchdog expiry
  localparam logic [7:0] CTRL_ZERO_WDOG_MASK = 8'h70;
  localparam logic [7:0] CURR_LIMIT_WDOG_MASK = 8'hbf;

  // ==========================================================
  // Analog settings in mV and mA
  localparam logic [12:0] SYS_FLOOR_MV_0 = 13'h0a28; // 2600
  localparam logic [12:0] SYS_FLOOR_MV_1 = 13'h0af0; // 2800
  localparam logic [12:0] SYS_FLOOR_MV_2 = 13'h0bb8; // 3000
  localparam logic [12:0] SYS_FLOOR_MV_3 = 13'h0c80; // 3200
  localparam logic [12:0] SYS_FLOOR_MV_4 = 13'h0d48; // 3400
  localparam logic [12:0] SYS_FLOOR_MV_5 = 13'h0dac; // 3500
  localparam logic [12:0] SYS_FLOOR_MV_6 = 13'h0e10; // 3600
  localparam logic [12:0] SYS_FLOOR_MV_7 = 13'h0e74; // 3700
  localparam logic [12:0] BOOST_EXIT_MV_LO = 13'h0af0; // 2800
  localparam logic [12:0] BOOST_START_MV_LO = 13'h0bb8; // 3000
  localparam logic [12:0] BOOST_EXIT_MV_HI = 13'h09c4; // 2500
  localparam logic [12:0] BOOST_START_MV_HI = 13'h0af0; // 2800
  localparam logic [11:0] BOOST_LIMIT_MA_LO = 12'h1f4; // 500
  localparam logic [11:0] BOOST_LIMIT_MA_HI = 12'h4b0; // 1200
  localparam logic [11:0] FAST_CHARGE_STEP_MA = 12'h03c; // 60
  localparam logic [5:0] FAST_CHARGE_MAX_CODE = 6'h32; // 3000 mA
  localparam logic [11:0] INPUT_LIMIT_STEP_MA = 12'h064; // 100
  localparam logic [11:0] INPUT_LIMIT_OFFSET_MA = 12'h064; // 100
  localparam logic [11:0] FET_FULL_ON_THRESH_MA = 12'h2bc; // 700

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_CHARGE = 2'b01,
    MODE_BOOST = 2'b10
  } chc_mode_type;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } chc_req_type;

  typedef struct packed {
    logic pulseFreqModeEn;
    logic watchdogKick;
    logic chargeActive;
    logic boostActive;
    logic inputFetFullOn;
    logic [12:0] sysFloorMv;
    logic [12:0] boostExitMv;
    logic [12:0] boostStartMv;
    logic [11:0] boostLimitMa;
    logic [11:0] chargeCurrentMa;
  } chc_ctl_type;

endpackage

/* File: test/charger_control_current_regs_bench.sv */
// Bench for the charger control register pair.
// Assumes chc_regs, its checker and the host model are compiled first.
`timescale 1ns/1ps

module charger_control_current_regs_bench;
  import chc_pkg::*;
  logic clock, rst, regResetCmd, watchdogExpired, chargeEnablePin_n, adapterPresent;
  logic boostOtherOk, regRdValid;
  logic [12:0] batteryMv;
  logic [4:0] inputLimitCode;
  logic [7:0] regRdData, rdv;
  chc_req_type regReq;
  chc_ctl_type ctl;
  int fails, checkCount, cyc;

  chc_host_model host_u (.clock(clock), .regReq(regReq), .regRdData(regRdData),
    .regRdValid(regRdValid));
  chc_regs dut_u (.clock(clock), .rst(rst), .regReq(regReq), .regRdData(regRdData),
    .regRdValid(regRdValid), .regResetCmd(regResetCmd), .watchdogExpired(watchdogExpired),
    .chargeEnablePin_n(chargeEnablePin_n), .adapterPresent(adapterPresent),
    .boostOtherOk(boostOtherOk), .batteryMv(batteryMv), .inputLimitCode(inputLimitCode),
    .ctl(ctl));

  // ========================================
  // Helpers
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic endOfTest;
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      endOfTest;
    end
  end
  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] s);
    checkCount++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, rdv);
    chk("read byte", {5'h00, e}, {5'h00, rdv});
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clock);
  endtask

  // ========================================
  // Scenarios
  task automatic tResetValues;
    rc(8'h01, 8'h1a);
    rc(8'h02, 8'h91);
    rc(8'h03, 8'h00);
    chk("pfm enable", 13'h0001, ctl.pulseFreqModeEn);
    chk("floor", 13'h0dac, ctl.sysFloorMv);
    chk("start", 13'h0bb8, ctl.boostStartMv);
    chk("current", 13'h03fc, ctl.chargeCurrentMa);
  endtask
  task automatic tWriteFields;
    host_u.wr(8'h01, 8'ha5);
    host_u.wr(8'h02, 8'hff);
    rc(8'h01, 8'ha5);
    rc(8'h02, 8'hff);
    chk("pfm enable", 13'h0000, ctl.pulseFreqModeEn);
    chk("floor", 13'h0bb8, ctl.sysFloorMv);
    chk("exit", 13'h09c4, ctl.boostExitMv);
    chk("boost limit", 13'h04b0, ctl.boostLimitMa);
    chk("current", 13'h0bb8, ctl.chargeCurrentMa);
    host_u.wr(8'h01, 8'h45);
    w(1);
    rc(8'h01, 8'h05);
    host_u.wr(8'h02, 8'h00);
    rc(8'h02, 8'h00);
    chk("boost limit", 13'h01f4, ctl.boostLimitMa);
    chk("current", 13'h0000, ctl.chargeCurrentMa);
  endtask
  task automatic tRestore;
    host_u.wr(8'h01, 8'ha5);
    host_u.wr(8'h02, 8'hff);
    w(1);
    watchdogExpired = 1'b1;
    w(1);
    watchdogExpired = 1'b0;
    rc(8'h01, 8'h95);
    rc(8'h02, 8'hd1);
    regResetCmd = 1'b1;
    w(1);
    regResetCmd = 1'b0;
    rc(8'h01, 8'h1a);
    rc(8'h02, 8'h91);
  endtask
  task automatic tModes;
    chargeEnablePin_n = 1'b0;
    w(3);
    chk("charge", 13'h0001, ctl.chargeActive);
    chk("fet full", 13'h0000, ctl.inputFetFullOn);
    host_u.wr(8'h02, 8'hd1);
    w(3);
    chk("fet full", 13'h0001, ctl.inputFetFullOn);
    host_u.wr(8'h01, 8'h3a);
    // Transistor bit back to partial so boost alone must force full on
    host_u.wr(8'h02, 8'h91);
    adapterPresent = 1'b0;
    w(3);
    chk("boost", 13'h0000, ctl.boostActive);
    batteryMv = 13'h0bb9;
    w(3);
    chk("boost", 13'h0001, ctl.boostActive);
    chk("fet full", 13'h0001, ctl.inputFetFullOn);
    adapterPresent = 1'b1;
    w(3);
    chk("charge", 13'h0001, ctl.chargeActive);
    host_u.wr(8'h02, 8'h80);
    inputLimitCode = 5'h07;
    w(3);
    chk("charge", 13'h0000, ctl.chargeActive);
    chk("fet full", 13'h0001, ctl.inputFetFullOn);
  endtask

  // ========================================
  // Main sequence
  initial begin
    rst = 1'b1;
    regResetCmd = 1'b0;
    watchdogExpired = 1'b0;
    chargeEnablePin_n = 1'b1;
    adapterPresent = 1'b1;
    boostOtherOk = 1'b1;
    batteryMv = 13'h0bb8;
    inputLimitCode = 5'h02;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    tResetValues;
    tWriteFields;
    tRestore;
    tModes;
    endOfTest;
  end
endmodule

/* File: test/chc_host_model.sv */
// Host side of the register port: byte writes and reads.
// Assumes the bench calls its tasks hierarchically.
`timescale 1ns/1ps

module chc_host_model
  import chc_pkg::*;
(
  input wire logic clock,
  output chc_req_type regReq,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid
);
  initial regReq = '0;
  // Whole byte write, strobe one cycle, then lines inverted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regReq = '{1'b1, 1'b0, a, d};
    @(negedge clock);
    regReq = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // Whole byte read, data taken with valid
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    regReq = '{1'b0, 1'b1, a, 8'h5a};
    @(negedge clock);
    regReq = '{1'b0, 1'b0, ~a, 8'ha5};
    d = regRdValid ? regRdData : 8'hxx;
  endtask
endmodule

/* File: test/chc_regs_assertions.sv */
// Checker for the charger control register pair.
// Assumes it is bound to chc_regs and sees only its ports.
`timescale 1ns/1ps

module chc_regs_checker
  import chc_pkg::*;
#(
  parameter int INPUT_LIMIT_WIDTH = 5
) (
  input wire logic clock,
  input wire logic rst,
  input wire chc_req_type regReq,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  input wire logic regResetCmd,
  input wire logic watchdogExpired,
  input wire logic chargeEnablePin_n,
  input wire logic adapterPresent,
  input wire logic boostOtherOk,
  input wire logic [12:0] batteryMv,
  input wire logic [INPUT_LIMIT_WIDTH-1:0] inputLimitCode,
  input wire chc_ctl_type ctl
);
  // ========================================
  // Setup
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic wr01;
  // Accepted write to control-zero
  assign wr01 = regReq.wrEn && regReq.addr == CTRL_ZERO_ADDR && !regResetCmd && !watchdogExpired;

  // ========================================
  // Assertions
  a_read_answer: assert property (regReq.rdEn |=> regRdValid)
    else $error("read strobe not answered");
  a_read_no_stray: assert property (regRdValid |-> $past(regReq.rdEn))
    else $error("read valid without request");
  a_kick_pulse: assert property (wr01 && regReq.wrData[6] |=>
    ##1 ctl.watchdogKick ##1 !ctl.watchdogKick)
    else $error("watchdog kick pulse wrong");
  a_pfm_follows: assert property (wr01 ##1 !regResetCmd |=>
    ctl.pulseFreqModeEn == !$past(regReq.wrData[7], 2))
    else $error("pulse skip setting not applied");
  a_reset_defaults: assert property (regResetCmd ##1 !regReq.wrEn |=>
    ctl.sysFloorMv == SYS_FLOOR_MV_5 && ctl.chargeCurrentMa == 12'h3fc)
    else $error("defaults not restored");
  a_current_clamp: assert property (ctl.chargeCurrentMa <= 12'hbb8)
    else $error("charge current above ceiling");
  a_charge_pin: assert property (ctl.chargeActive |-> !$past(chargeEnablePin_n))
    else $error("charging with enable pin high");
  a_boost_start: assert property ($rose(ctl.boostActive) |->
    $past(batteryMv) > ctl.boostStartMv)
    else $error("boost started below threshold");
  a_fet_boost: assert property (ctl.boostActive [*2] |-> ctl.inputFetFullOn)
    else $error("input transistor not full in boost");
  a_fet_limit: assert property ((inputLimitCode > 6) [*2] |-> ctl.inputFetFullOn)
    else $error("input transistor not full above limit");
  c_boost: cover property ($rose(ctl.boostActive));
  c_charge: cover property ($rose(ctl.chargeActive));
  c_kick: cover property (ctl.watchdogKick);
endmodule

bind chc_regs chc_regs_checker #(.INPUT_LIMIT_WIDTH(INPUT_LIMIT_WIDTH)) chk_u (.clock(clock),
  .rst(rst), .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid),
  .regResetCmd(regResetCmd), .watchdogExpired(watchdogExpired),
  .chargeEnablePin_n(chargeEnablePin_n), .adapterPresent(adapterPresent),
  .boostOtherOk(boostOtherOk), .batteryMv(batteryMv), .inputLimitCode(inputLimitCode),
  .ctl(ctl));
